// ==== design/sspb_top.sv ====
// Behaviour
// - sixteen byte payload, fields in fixed order
// - reply only to a status request
// - output bits 0-2 carry compressor faults
// - output bits 3-8 states, 9-15 reserved
// - input bits 0-2 enables and reset
// - input bits 3-5 fault inputs
// - input bits 6-8 spares, rest reserved
// - button bits 0-3, rest reserved
// - fault bits 0-4 system, fuses, overload, phase
// - fault bits 5-6 pressure and temperature
// - fault bits 7-8 phase count mismatch
// - multi-byte fields sent low byte first
// - reply id 10, request id 229
// - crc8 poly 0x07 over command and payload
`timescale 1ns/1ps
`include "sspb_params.svh"

module sspb_top (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic req_valid,
	input wire logic [7:0] req_cmd,
	input wire logic [7:0] req_crc_seed,
	input wire logic [31:0] run_time_s,
	input wire logic [15:0] temp_dc,
	input wire logic [15:0] voltage_mv,
	input wire sspb_pkg::sspb_outs_s out_state,
	input wire sspb_pkg::sspb_ins_s in_pins,
	input wire sspb_pkg::sspb_btns_s btn_pins,
	input wire sspb_pkg::sspb_faults_s faults,
	output logic tx_valid,
	input wire logic tx_ready,
	output sspb_pkg::sspb_byte_s tx_byte,
	output logic busy
);
	// ==========================================
	// bitmap builders
	function automatic logic [15:0] out_map(input sspb_pkg::sspb_outs_s s);
		logic [15:0] v;
		v = 16'h0000; // reserved bits stay clear
		v[`SSPB_OUT_PRESS] = s.press_fault;
		v[`SSPB_OUT_TEMP] = s.temp_fault;
		v[`SSPB_OUT_PHASE] = s.phase_err;
		v[`SSPB_OUT_RUN] = s.running;
		v[`SSPB_OUT_FAN] = s.fan_on;
		v[`SSPB_OUT_COMP] = s.comp_on;
		v[`SSPB_OUT_COLD] = s.coldhead_on;
		v[`SSPB_OUT_SPARE1] = s.spare1;
		v[`SSPB_OUT_SPARE2] = s.spare2;
		return v;
	endfunction

	function automatic logic [15:0] in_map(input sspb_pkg::sspb_ins_s s);
		logic [15:0] v;
		v = 16'h0000;
		v[`SSPB_IN_COLD_EN] = s.coldhead_enable;
		v[`SSPB_IN_COMP_EN] = s.comp_enable;
		v[`SSPB_IN_SYSRST] = s.sys_reset;
		v[`SSPB_IN_PRESS] = s.press_fault;
		v[`SSPB_IN_TEMP] = s.temp_fault;
		v[`SSPB_IN_OVLD] = s.overload;
		v[`SSPB_IN_REMOTE1] = s.spare_remote1;
		v[`SSPB_IN_REMOTE2] = s.spare_remote2;
		v[`SSPB_IN_CHASSIS] = s.spare_chassis;
		return v;
	endfunction

	function automatic logic [15:0] btn_map(input sspb_pkg::sspb_btns_s s);
		logic [15:0] v;
		v = 16'h0000;
		v[`SSPB_BTN_ON] = s.on;
		v[`SSPB_BTN_OFF] = s.off;
		v[`SSPB_BTN_MENU] = s.menu;
		v[`SSPB_BTN_HIST] = s.history;
		return v;
	endfunction

	function automatic logic [15:0] flt_map(input sspb_pkg::sspb_faults_s s);
		logic [15:0] v;
		v = 16'h0000;
		v[`SSPB_FLT_SYS] = s.system;
		v[`SSPB_FLT_FUSE220] = s.fuse_220v;
		v[`SSPB_FLT_FUSE24] = s.fuse_24v;
		v[`SSPB_FLT_OVLD] = s.comp_overload;
		v[`SSPB_FLT_PHASE] = s.ac_phase;
		v[`SSPB_FLT_PRESS] = s.comp_press;
		v[`SSPB_FLT_TEMP] = s.comp_temp;
		v[`SSPB_FLT_3SEEN1] = s.three_seen_one;
		v[`SSPB_FLT_1SEEN3] = s.one_seen_three;
		return v;
	endfunction

	// ==========================================
	// pin synchronisers for front-panel and remote inputs
	sspb_pkg::sspb_ins_s in_meta; // first stage, read only by in_sync
	sspb_pkg::sspb_ins_s in_sync; // second stage
	sspb_pkg::sspb_btns_s btn_meta; // first stage, read only by btn_sync
	sspb_pkg::sspb_btns_s btn_sync; // second stage

	// two flops per pin
	always_ff @(posedge clk) begin
		if (srst) begin
			in_meta <= '0;
			in_sync <= '0;
			btn_meta <= '0;
			btn_sync <= '0;
		end else begin
			in_meta <= in_pins;
			in_sync <= in_meta;
			btn_meta <= btn_pins;
			btn_sync <= btn_meta;
		end
	end

	// ==========================================
	// state and registers
	sspb_pkg::sspb_state_e state; // reply sequencer
	sspb_pkg::sspb_state_e next_state;
	sspb_pkg::sspb_payload_s snap; // frozen payload image
	logic [3:0] idx; // payload byte index
	logic ctrl_en; // replies allowed
	logic missed; // request arrived while busy, sticky
	logic [31:0] reply_count; // replies completed
	logic [7:0] crc; // running crc
	logic buf_ready; // buffer can take a byte
	logic wr_pend; // write data phase pending
	logic [7:0] wr_addr; // address of pending write

	// ==========================================
	// request decode
	// a request met while busy is dropped and flagged; while disabled it is ignored
	wire is_status_req = req_valid && (req_cmd == `SSPB_REQ_ID);
	wire idle = (state == sspb_pkg::ST_IDLE);
	wire req_take = is_status_req && idle && ctrl_en;
	wire miss_evt = is_status_req && ctrl_en && !idle;

	// coherent image of every reported value, taken in one cycle
	wire sspb_pkg::sspb_payload_s live = '{
		fault_map: flt_map(faults),
		button_map: btn_map(btn_sync),
		input_map: in_map(in_sync),
		output_map: out_map(out_state),
		voltage_mv: voltage_mv,
		temp_dc: temp_dc,
		run_time_s: run_time_s
	};

	// byte picked from the image, lowest byte first
	wire [127:0] snap_flat = snap;
	wire [7:0] pay_byte = snap_flat[{idx, 3'h0} +: 8];

	// ==========================================
	// byte selection toward the buffer
	wire push = !idle && buf_ready;
	wire last_pay = (idx == `SSPB_PAY_LAST);
	wire [7:0] push_data = (state == sspb_pkg::ST_CMD) ? `SSPB_REPLY_ID :
		(state == sspb_pkg::ST_PAY) ? pay_byte : crc;
	wire push_last = (state == sspb_pkg::ST_CRC);
	wire crc_update = push && !push_last;
	wire sspb_pkg::sspb_byte_s push_byte = '{last: push_last, data: push_data};

	// ==========================================
	// sequencer next state
	always_comb begin
		next_state = state;
		unique case (state)
			// wait for a status request
			sspb_pkg::ST_IDLE: begin
				if (req_take) begin
					next_state = sspb_pkg::ST_CMD;
				end
			end
			// command byte
			sspb_pkg::ST_CMD: begin
				if (push) begin
					next_state = sspb_pkg::ST_PAY;
				end
			end
			// sixteen payload bytes
			sspb_pkg::ST_PAY: begin
				if (push && last_pay) begin
					next_state = sspb_pkg::ST_CRC;
				end
			end
			// check byte closes the reply
			sspb_pkg::ST_CRC: begin
				if (push) begin
					next_state = sspb_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// sequencer, snapshot and counters
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= sspb_pkg::ST_IDLE;
			snap <= '0;
			idx <= 4'h0;
			busy <= 1'b0;
			reply_count <= 32'h0000_0000;
		end else begin
			state <= next_state;
			busy <= (next_state != sspb_pkg::ST_IDLE);
			// image and byte index restart together, so one reply never mixes two samples
			if (req_take) begin
				snap <= live;
				idx <= 4'h0;
			end else if (push && state == sspb_pkg::ST_PAY) begin
				idx <= idx + 4'h1;
			end
			// a reply counts once its check byte enters the buffer
			if (push && push_last) begin
				reply_count <= reply_count + 32'h0000_0001;
			end
		end
	end

	// ==========================================
	// crc engine and output buffer
	// the framer's header crc seeds the register as a request is taken
	sspb_crc8 u_crc (
		.clk(clk),
		.srst(srst),
		.load(req_take),
		.seed(req_crc_seed),
		.update(crc_update),
		.data(push_data),
		.crc(crc)
	);

	// a stalled byte stays put and one more waits behind it, so nothing is lost
	sspb_buf2 #(.WIDTH(9)) u_buf (
		.clk(clk),
		.srst(srst),
		.in_valid(push),
		.in_ready(buf_ready),
		.in_data(push_byte),
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data(tx_byte)
	);

	// ==========================================
	// ahb-lite slave
	// zero wait states: hreadyout never drops, every transfer takes two cycles
	// unmapped addresses read as zero and ignore writes
	wire addr_ok = hsel && htrans[1] && hready; // nonseq or seq address phase
	wire rd_take = addr_ok && !hwrite;
	wire wr_now = wr_pend; // data phase of a write
	wire wr_ctrl = wr_now && (wr_addr == `SSPB_CTRL_OFS);
	wire wr_stat = wr_now && (wr_addr == `SSPB_STATUS_OFS);
	wire next_ctrl_en = wr_ctrl ? hwdata[`SSPB_CTRL_EN_BIT] : ctrl_en;
	// hardware set wins over a write-one clear
	wire clr_miss = wr_stat && hwdata[`SSPB_STAT_MISSED_BIT];
	wire next_missed = miss_evt || (missed && !clr_miss);
	wire next_busy = (next_state != sspb_pkg::ST_IDLE);

	// control and status read data reflect register values after this edge
	wire [31:0] rd_ctrl = {31'h0, next_ctrl_en};
	wire [31:0] rd_stat = {30'h0, next_missed, next_busy};
	wire [7:0] rd_ofs = haddr[7:0];
	wire [31:0] rd_val = (haddr[31:8] != 24'h0) ? 32'h0000_0000 :
		(rd_ofs == `SSPB_CTRL_OFS) ? rd_ctrl :
		(rd_ofs == `SSPB_STATUS_OFS) ? rd_stat :
		(rd_ofs == `SSPB_COUNT_OFS) ? reply_count :
		(rd_ofs == `SSPB_RUNTIME_OFS) ? snap.run_time_s : 32'h0000_0000;

	// bus phases and software registers
	always_ff @(posedge clk) begin
		if (srst) begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h0000_0000;
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
			ctrl_en <= `SSPB_CTRL_RESET;
			missed <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wr_pend <= addr_ok && hwrite && (haddr[31:8] == 24'h0);
			wr_addr <= haddr[7:0];
			ctrl_en <= next_ctrl_en;
			missed <= next_missed;
			// read data is loaded at the address phase and stands in the data phase
			if (rd_take) begin
				hrdata <= rd_val;
			end
		end
	end
endmodule

// ==== pkg/sspb_params.svh ====
`ifndef SSPB_PARAMS_SVH
`define SSPB_PARAMS_SVH

// ==========================================
// packet codes and sizes
`define SSPB_REQ_ID 8'he5
`define SSPB_REPLY_ID 8'h0a
`define SSPB_PAY_LAST 4'hf
`define SSPB_CRC_POLY 8'h07
`define SSPB_CRC_SEED 8'h00

// ==========================================
// register byte offsets (low address byte)
`define SSPB_CTRL_OFS 8'h00
`define SSPB_STATUS_OFS 8'h04
`define SSPB_COUNT_OFS 8'h08
`define SSPB_RUNTIME_OFS 8'h0c
`define SSPB_CTRL_EN_BIT 0
`define SSPB_CTRL_RESET 1'h1
`define SSPB_STAT_BUSY_BIT 0
`define SSPB_STAT_MISSED_BIT 1

// ==========================================
// output-state bitmap positions
`define SSPB_OUT_PRESS 0
`define SSPB_OUT_TEMP 1
`define SSPB_OUT_PHASE 2
`define SSPB_OUT_RUN 3
`define SSPB_OUT_FAN 4
`define SSPB_OUT_COMP 5
`define SSPB_OUT_COLD 6
`define SSPB_OUT_SPARE1 7
`define SSPB_OUT_SPARE2 8

// ==========================================
// input-state bitmap positions
`define SSPB_IN_COLD_EN 0
`define SSPB_IN_COMP_EN 1
`define SSPB_IN_SYSRST 2
`define SSPB_IN_PRESS 3
`define SSPB_IN_TEMP 4
`define SSPB_IN_OVLD 5
`define SSPB_IN_REMOTE1 6
`define SSPB_IN_REMOTE2 7
`define SSPB_IN_CHASSIS 8

// ==========================================
// button and fault bitmap positions
`define SSPB_BTN_ON 0
`define SSPB_BTN_OFF 1
`define SSPB_BTN_MENU 2
`define SSPB_BTN_HIST 3
`define SSPB_FLT_SYS 0
`define SSPB_FLT_FUSE220 1
`define SSPB_FLT_FUSE24 2
`define SSPB_FLT_OVLD 3
`define SSPB_FLT_PHASE 4
`define SSPB_FLT_PRESS 5
`define SSPB_FLT_TEMP 6
`define SSPB_FLT_3SEEN1 7
`define SSPB_FLT_1SEEN3 8

`endif

// ==== pkg/sspb_pkg.sv ====
package sspb_pkg;
	// ==========================================
	// discrete status groups
	typedef struct packed {
		logic spare2, spare1, coldhead_on, comp_on, fan_on, running, phase_err, temp_fault, press_fault;
	} sspb_outs_s;
	typedef struct packed {
		logic spare_chassis, spare_remote2, spare_remote1, overload, temp_fault, press_fault;
		logic sys_reset, comp_enable, coldhead_enable;
	} sspb_ins_s;
	typedef struct packed {
		logic history, menu, off, on;
	} sspb_btns_s;
	typedef struct packed {
		logic one_seen_three, three_seen_one, comp_temp, comp_press, ac_phase;
		logic comp_overload, fuse_24v, fuse_220v, system;
	} sspb_faults_s;

	// ==========================================
	// payload image: low bits go out first
	typedef struct packed {
		logic [15:0] fault_map;
		logic [15:0] button_map;
		logic [15:0] input_map;
		logic [15:0] output_map;
		logic [15:0] voltage_mv;
		logic signed [15:0] temp_dc;
		logic [31:0] run_time_s;
	} sspb_payload_s;

	// one byte of the reply stream
	typedef struct packed {
		logic last;
		logic [7:0] data;
	} sspb_byte_s;

	typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_PAY, ST_CRC} sspb_state_e;
endpackage

// ==== design/sspb_crc8.sv ====
`timescale 1ns/1ps
`include "sspb_params.svh"

// running crc register, loaded with a seed and folded one byte at a time
module sspb_crc8 (
	input wire logic clk,
	input wire logic srst,
	input wire logic load,
	input wire logic [7:0] seed,
	input wire logic update,
	input wire logic [7:0] data,
	output logic [7:0] crc
);
	// ==========================================
	// byte fold, msb first
	function automatic logic [7:0] fold(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] v;
		v = c ^ d;
		for (int i = 0; i < 8; i++) begin
			v = v[7] ? ((v << 1) ^ `SSPB_CRC_POLY) : (v << 1);
		end
		return v;
	endfunction

	// crc state
	always_ff @(posedge clk) begin
		if (srst) begin
			crc <= `SSPB_CRC_SEED;
		end else if (load) begin
			crc <= seed;
		end else if (update) begin
			crc <= fold(crc, data);
		end
	end
endmodule

// ==== design/sspb_buf2.sv ====
`timescale 1ns/1ps

// two-entry buffer: head register drives the outputs, spare entry absorbs a stall
module sspb_buf2 #(
	parameter int WIDTH = 9
) (
	input wire logic clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic spare_valid; // spare entry holds a word
	logic [WIDTH-1:0] spare_data; // spare entry contents
	wire take = in_valid && in_ready; // word enters
	wire give = out_valid && out_ready; // word leaves

	// ==========================================
	// entries
	always_ff @(posedge clk) begin
		if (srst) begin
			out_valid <= 1'b0;
			spare_valid <= 1'b0;
			in_ready <= 1'b1;
			out_data <= '0;
			spare_data <= '0;
		end else begin
			// head refills from spare first, else from the input
			if (!out_valid || give) begin
				out_valid <= spare_valid || take;
				out_data <= spare_valid ? spare_data : in_data;
			end
			// spare fills when head is held and a word arrives
			if (take && out_valid && !give) begin
				spare_valid <= 1'b1;
				spare_data <= in_data;
			end else if (give) begin
				spare_valid <= 1'b0;
			end
			// full once both entries hold words
			in_ready <= !((spare_valid && !give) || (take && out_valid && !give));
		end
	end
endmodule

// ==== dv/sspb_assertions.sv ====
`timescale 1ns/1ps

// ==========================================
// stream and bus checks on the top ports
module sspb_checker (
	input wire logic clk,
	input wire logic srst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	input wire logic req_valid,
	input wire logic [7:0] req_cmd,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire sspb_pkg::sspb_byte_s tx_byte,
	input wire logic busy
);
	logic [4:0] n; // bytes accepted in the current reply

	// count accepted bytes, restart after the closing byte
	always_ff @(posedge clk) begin
		if (srst) n <= 5'h0;
		else if (tx_valid && tx_ready) n <= tx_byte.last ? 5'h0 : n + 5'h1;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (srst);

	sequence s_start;
		!busy ##1 busy;
	endsequence
	sequence s_lead;
		tx_valid && tx_byte.data == 8'h0a;
	endsequence

	a_reply_only: assert property (s_start |-> $past(req_valid) && $past(req_cmd) == 8'he5)
		else $error("reply started without status request");
	a_cmd_lead: assert property (s_start |=> s_lead)
		else $error("reply id not offered one cycle after busy");
	a_frame_len: assert property (tx_valid && tx_ready |-> tx_byte.last == (n == 5'd17))
		else $error("closing byte not at position eighteen");
	a_frame_cmd: assert property (tx_valid && tx_ready && n == 5'd0 |-> tx_byte.data == 8'h0a)
		else $error("first reply byte is not the reply id");
	a_byte_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte))
		else $error("stalled byte changed or vanished");
	a_idle_quiet: assert property (!busy && !tx_valid |=> !tx_valid)
		else $error("byte offered while idle");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	a_unmap_zero: assert property (hsel && htrans[1] && hready && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
endmodule

bind sspb_top sspb_checker u_sspb_checker (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hready, .hreadyout,
	.hresp, .hrdata, .req_valid, .req_cmd, .tx_valid, .tx_ready, .tx_byte, .busy);

// ==== dv/sspb_sink.sv ====
`timescale 1ns/1ps

// ==========================================
// host side: takes reply bytes, may stall
module sspb_sink (
	input wire logic clk,
	input wire logic srst,
	input wire logic slow,
	input wire logic hold,
	input wire logic tx_valid,
	input wire sspb_pkg::sspb_byte_s tx_byte,
	output logic tx_ready,
	output logic [31:0] rt_seen
);
	logic [4:0] idx; // byte position in the reply
	logic [3:0] ph; // stall pattern phase

	// reassemble run time, low byte first
	always_ff @(posedge clk) begin
		if (srst) begin
			idx <= 5'h0;
			ph <= 4'h0;
			rt_seen <= 32'h0;
		end else begin
			ph <= ph + 4'h1;
			if (tx_valid && tx_ready) begin
				idx <= tx_byte.last ? 5'h0 : idx + 5'h1;
				if (idx >= 5'd1 && idx <= 5'd4) rt_seen[8 * (idx - 5'd1) +: 8] <= tx_byte.data;
			end
		end
	end

	assign tx_ready = !hold && (!slow || (ph[0] ^ ph[2]));
endmodule

// ==== dv/tb_status_response_payload_builder.sv ====
`timescale 1ns/1ps

// ==========================================
// status reply bench
module tb_status_response_payload_builder;
	logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, req_valid = 1'b0, slow = 1'b0, hold = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, run_time_s = 32'h0, seed = 32'h39e5, rd, hrdata, rt_seen;
	logic [7:0] req_cmd = 8'h0, req_crc_seed = 8'h0;
	logic [15:0] temp_dc = 16'h0, voltage_mv = 16'h0;
	sspb_pkg::sspb_outs_s out_state = '0;
	sspb_pkg::sspb_ins_s in_pins = '0;
	sspb_pkg::sspb_btns_s btn_pins = '0;
	sspb_pkg::sspb_faults_s faults = '0;
	sspb_pkg::sspb_byte_s tx_byte;
	logic hreadyout, hresp, tx_valid, tx_ready, busy;
	logic [8:0] q[$]; // expected bytes, oldest first
	int bad_count = 0, cmp_count = 0, cyc = 0, nrep = 0;

	sspb_top u_sspb_top (.clk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hreadyout, .hresp, .hrdata, .req_valid, .req_cmd, .req_crc_seed, .run_time_s,
		.temp_dc, .voltage_mv, .out_state, .in_pins, .btn_pins, .faults, .tx_valid, .tx_ready, .tx_byte, .busy);
	sspb_sink u_sspb_sink (.clk, .srst, .slow, .hold, .tx_valid, .tx_byte, .tx_ready, .rt_seen);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = {seed[30:0], ^(seed & 32'h80200003)};
		return seed;
	endfunction

	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
		c ^= d;
		for (int i = 0; i < 8; i++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		return c;
	endfunction

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			bad_count++;
			$display("ERROR %s exp %h seen %h", n, e, s);
		end
	endtask

	task close_out;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// one single-word bus transfer, read data left in rd
	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// request that must not start a reply
	task pulse(input logic [7:0] cmd);
		@(posedge clk);
		req_valid <= 1'b1;
		req_cmd <= cmd;
		@(posedge clk);
		req_valid <= 1'b0;
		repeat (3) @(posedge clk);
		chk("busy idle", {31'h0, busy}, 32'h0);
	endtask

	// random status, one request (plus one more while busy when dup), expected reply queued
	task frame(input logic dup);
		logic [31:0] a, b, e;
		logic [127:0] p;
		logic [7:0] c;
		a = rnd();
		b = rnd();
		e = rnd();
		@(posedge clk);
		run_time_s <= a;
		temp_dc <= b[15:0];
		voltage_mv <= b[31:16];
		out_state <= e[8:0];
		in_pins <= e[17:9];
		btn_pins <= e[21:18];
		faults <= e[30:22];
		req_crc_seed <= a[7:0] ^ b[15:8];
		p = {7'h0, e[30:22], 12'h0, e[21:18], 7'h0, e[17:9], 7'h0, e[8:0], b, a};
		c = crc8(a[7:0] ^ b[15:8], 8'h0a);
		q.push_back({1'b0, 8'h0a});
		for (int i = 0; i < 16; i++) begin
			c = crc8(c, p[8 * i +: 8]);
			q.push_back({1'b0, p[8 * i +: 8]});
		end
		q.push_back({1'b1, c});
		repeat (4) @(posedge clk);
		req_valid <= 1'b1;
		req_cmd <= 8'he5;
		@(posedge clk);
		req_valid <= 1'b0;
		run_time_s <= ~a;
		faults <= ~e[30:22];
		if (dup) begin
			repeat (2) @(posedge clk);
			req_valid <= 1'b1;
			@(posedge clk);
			req_valid <= 1'b0;
		end
		ahb(1'b0, 32'h4, 32'h0);
		chk("status busy", {31'h0, rd[0]}, 32'h1);
		nrep++;
		repeat (30) @(posedge clk);
		hold <= 1'b0;
		while (q.size() != 0 || busy !== 1'b0) @(posedge clk);
		chk("host runtime", rt_seen, a);
		ahb(1'b0, 32'hc, 32'h0);
		chk("runtime reg", rd, a);
		ahb(1'b0, 32'h8, 32'h0);
		chk("count reg", rd, 32'(nrep));
	endtask

	// compare each accepted byte with the oldest note
	always @(posedge clk) begin
		if (!srst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (q.size() == 0) chk("extra byte", 32'h1, 32'h0);
			else chk("reply byte", {23'h0, tx_byte}, {23'h0, q.pop_front()});
		end
	end

	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			close_out;
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		ahb(1'b0, 32'h0, 32'h0);
		chk("ctrl reset", rd, 32'h1);
		ahb(1'b0, 32'h100, 32'h0);
		chk("unmapped", rd, 32'h0);
		frame(1'b0);
		slow <= 1'b1;
		frame(1'b0);
		frame(1'b1);
		ahb(1'b0, 32'h4, 32'h0);
		chk("status missed", rd, 32'h2);
		ahb(1'b1, 32'h4, 32'h2);
		ahb(1'b0, 32'h4, 32'h0);
		chk("status clear", rd, 32'h0);
		hold <= 1'b1;
		frame(1'b0);
		ahb(1'b1, 32'h0, 32'h0);
		pulse(8'he5);
		ahb(1'b1, 32'h0, 32'h1);
		pulse(8'h0a);
		pulse(8'h35);
		pulse(8'he2);
		repeat (4) @(posedge clk);
		close_out;
	end
endmodule
